// file: windowed_supervisor.v
// Window watchdog supervising the microcontroller
`timescale 1ns/1ps
`include "wwd_defs.vh"

// What this block does
// - Trigger source pin edge or command; command default
// - Each trigger gives verdict, ends open window
// - Valid trigger starts a closed window
// - Missed open trigger: invalid, reopen
// - Accumulated errors pull reset output low
// - Open and closed window lengths are cycle time times count
// - Error threshold is software writable
// - Reset release starts a long open window
// - Default: long window takes command trigger only
// - Reconfiguring in long window restarts regular window
// - Long window expiry adds no error, raises no interrupt
// - Init timeout: soft reset, new long window
// - Second failed long window: hard fault
// - Valid long-window trigger starts configured closed window
// - Trigger in closed window: invalid, reopen early
// - Invalid adds two and raises interrupt
// - Closed window expiry starts open window
// - Valid open trigger subtracts one above zero
// - Verdict is internal, feeds error counter and interrupt
// - Pin valid after two highs, two lows
// - Long window 600 ms or 60 ms
// - Rising pin edge never triggers
// - Errors accumulate until threshold resets
module windowed_supervisor #(
  parameter LOW_LONG_CYC  = `LOW_LONG_CYC,
  parameter LOW_SHORT_CYC = `LOW_SHORT_CYC,
  parameter INIT_CYC      = `LOW_LONG_CYC,
  parameter SAMPLE_CYC    = 16,
  parameter RST_HOLD_CYC  = 16
) (
  input  wire                clk_i,
  input  wire                rstn_i,
  input  wire                trigger_input_pin_i,
  input  wire                cmd_write_i,
  input  wire                trigger_source_i,
  input  wire                trigger_source_we_i,
  input  wire                cycle_time_select_i,
  input  wire [31:0]         cycle_unit_i,
  input  wire [15:0]         open_window_count_i,
  input  wire [15:0]         closed_window_setting_i,
  input  wire                timing_we_i,
  input  wire [`ERR_W-1:0]   error_count_limit_i,
  input  wire                error_count_limit_we_i,
  output reg                 mcu_reset_output_o,
  output reg                 wdg_irq_o,
  output reg                 fault_o,
  output reg                 regulators_off_o,
  output reg  [`ERR_W-1:0]   error_count_o,
  output reg  [1:0]          window_state_o
);
  ////////////////////////////////////////////////////////////////////////////
  // States
  localparam ST_OFF    = 3'd0;
  localparam ST_LONG   = 3'd1;
  localparam ST_CLOSED = 3'd2;
  localparam ST_OPEN   = 3'd3;
  localparam ST_RESET  = 3'd4;
  localparam ST_FAULT  = 3'd5;

  // Status codes of the window state copy
  localparam WS_IDLE   = 2'h0;
  localparam WS_LONG   = 2'h1;
  localparam WS_CLOSED = 2'h2;
  localparam WS_OPEN   = 2'h3;

  reg [2:0]        state_q;
  reg              src_q;
  reg [31:0]       unit_q;
  reg [15:0]       ow_q;
  reg [15:0]       cw_q;
  reg [`ERR_W-1:0] limit_q;
  reg [`ERR_W-1:0] err_q;
  reg              second_long_q;
  reg [31:0]       init_q;
  reg [15:0]       hold_q;
  reg              load;
  reg [31:0]       len;
  reg              verdict_ev;
  reg              verdict_ok;
  wire             pin_fall;
  wire             expire;
  wire             trig;
  // Window lengths in clock cycles
  wire [31:0]      ow_len = unit_q * {16'h0000, ow_q};
  wire [31:0]      cw_len = unit_q * {16'h0000, cw_q};
  // Open length from settings being written, so a rewrite takes effect at once
  wire [31:0]      ow_len_new = cycle_unit_i * {16'h0000, open_window_count_i};
  wire [31:0]      low_len = cycle_time_select_i ? LOW_LONG_CYC : LOW_SHORT_CYC;
  wire [`ERR_W:0]  err_add = {1'b0, err_q} + {1'b0, `ERR_INC};
  wire             reconf = trigger_source_we_i | timing_we_i;

  ////////////////////////////////////////////////////////////////////////////
  // Trigger sources
  trigger_edge_filter #(
    .SAMPLE_CYC (SAMPLE_CYC)
  ) u_filter (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .pin_i  (trigger_input_pin_i),
    .fall_o (pin_fall)
  );

  // Selected trigger only; pin ignored when command selected
  assign trig = (src_q == `SRC_PIN) ? pin_fall : cmd_write_i;

  // One timer serves every window, reloaded at each change
  window_timer #(
    .W (32)
  ) u_timer (
    .clk_i    (clk_i),
    .rstn_i   (rstn_i),
    .load_i   (load),
    .len_i    (len),
    .expire_o (expire)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Configuration, writable while running
  always @(posedge clk_i) begin
    if (!rstn_i) begin
      src_q   <= `SRC_SPI;
      unit_q  <= `CYC_UNIT_RST;
      ow_q    <= `OW_CNT_RST;
      cw_q    <= `CW_CNT_RST;
      limit_q <= `ERR_LIMIT_RST;
    end else begin
      if (trigger_source_we_i)
        src_q <= trigger_source_i;
      if (timing_we_i) begin
        unit_q <= cycle_unit_i;
        ow_q   <= open_window_count_i;
        cw_q   <= closed_window_setting_i;
      end
      if (error_count_limit_we_i)
        limit_q <= error_count_limit_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Window sequencing, produces internal verdict
  always @* begin
    load       = 1'b0;
    len        = ow_len;
    verdict_ev = 1'b0;
    verdict_ok = 1'b0;
    case (state_q)
      // Wait for reset output release
      ST_OFF: begin
        if (mcu_reset_output_o) begin
          load = 1'b1;
          len  = low_len;
        end
      end
      // Long window ends on trigger or reconfiguration
      ST_LONG: begin
        if (trig) begin
          verdict_ev = 1'b1;
          verdict_ok = 1'b1;
          load       = 1'b1;
          len        = cw_len;
        end else if (reconf) begin
          load = 1'b1;
          len  = timing_we_i ? ow_len_new : ow_len;
        end
      end
      // Open window: trigger valid, expiry invalid
      ST_OPEN: begin
        if (trig) begin
          verdict_ev = 1'b1;
          verdict_ok = 1'b1;
          load       = 1'b1;
          len        = cw_len;
        end else if (expire) begin
          verdict_ev = 1'b1;
          load       = 1'b1;
          len        = ow_len;
        end
      end
      // Closed window: trigger invalid, expiry reopens
      ST_CLOSED: begin
        if (trig) begin
          verdict_ev = 1'b1;
          load       = 1'b1;
          len        = ow_len;
        end else if (expire) begin
          load = 1'b1;
          len  = ow_len;
        end
      end
      default: begin
        load = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State, error counter, reset output and interrupt
  always @(posedge clk_i) begin
    if (!rstn_i) begin
      state_q            <= ST_OFF;
      err_q              <= `ERR_RST;
      second_long_q      <= 1'b0;
      init_q             <= 32'h00000000;
      hold_q             <= 16'h0000;
      mcu_reset_output_o <= 1'b0;
      wdg_irq_o          <= 1'b0;
      fault_o            <= 1'b0;
      regulators_off_o   <= 1'b0;
    end else begin
      wdg_irq_o <= 1'b0;
      case (state_q)
        // Release reset output, then open the long window
        ST_OFF: begin
          mcu_reset_output_o <= 1'b1;
          if (mcu_reset_output_o) begin
            state_q <= ST_LONG;
            init_q  <= 32'h00000000;
            err_q   <= `ERR_RST;
          end
        end
        // Long window: trigger, reconfiguration or loss
        ST_LONG: begin
          init_q <= init_q + 32'h00000001;
          if (trig) begin
            state_q       <= ST_CLOSED;
            second_long_q <= 1'b0;
          end else if (reconf) begin
            state_q       <= ST_OPEN;
            second_long_q <= 1'b0;
          end else if (expire || init_q >= INIT_CYC - 1) begin
            // Long window lost: soft reset, then hard fault
            if (second_long_q) begin
              state_q          <= ST_FAULT;
              fault_o          <= 1'b1;
              regulators_off_o <= 1'b1;
              mcu_reset_output_o <= 1'b0;
            end else begin
              state_q            <= ST_RESET;
              second_long_q      <= 1'b1;
              mcu_reset_output_o <= 1'b0;
              hold_q             <= 16'h0000;
            end
          end
        end
        ST_RESET: begin
          // Soft reset pulse, no interrupt raised
          hold_q <= hold_q + 16'h0001;
          if (hold_q >= RST_HOLD_CYC - 1)
            state_q <= ST_OFF;
        end
        // Regular windows: next window and error count
        ST_OPEN, ST_CLOSED: begin
          if (trig && state_q == ST_OPEN)
            state_q <= ST_CLOSED;
          else if (load)
            state_q <= ST_OPEN;
          // Verdict drives error counter and interrupt
          if (verdict_ev && verdict_ok) begin
            if (err_q != {`ERR_W{1'b0}})
              err_q <= err_q - `ERR_DEC;
          end else if (verdict_ev) begin
            wdg_irq_o <= 1'b1;
            if (err_add >= {1'b0, limit_q}) begin
              err_q              <= `ERR_RST;
              state_q            <= ST_RESET;
              mcu_reset_output_o <= 1'b0;
              hold_q             <= 16'h0000;
              second_long_q      <= 1'b0;
            end else begin
              err_q <= err_add[`ERR_W-1:0];
            end
          end
        end
        // Failure holds reset output low
        ST_FAULT: begin
          mcu_reset_output_o <= 1'b0;
        end
        default: begin
          state_q <= ST_OFF;
        end
      endcase
    end
  end

  // Status copies
  always @(posedge clk_i) begin
    if (!rstn_i) begin
      error_count_o  <= `ERR_RST;
      window_state_o <= WS_IDLE;
    end else begin
      error_count_o  <= err_q;
      window_state_o <= (state_q == ST_LONG) ? WS_LONG : (state_q == ST_CLOSED) ? WS_CLOSED :
                        (state_q == ST_OPEN) ? WS_OPEN : WS_IDLE;
    end
  end
endmodule

// file: wwd_defs.vh
// Timing and field constants of the windowed supervisor
`ifndef WWD_DEFS_VH
`define WWD_DEFS_VH
`define CLK_PERIOD_NS        8
`define LOW_LONG_MS          600
`define LOW_SHORT_MS         60
`define LOW_LONG_CYC         ((`LOW_LONG_MS * 1000000) / `CLK_PERIOD_NS)
`define LOW_SHORT_CYC        ((`LOW_SHORT_MS * 1000000) / `CLK_PERIOD_NS)
`define ERR_INC              8'h02
`define ERR_DEC              8'h01
`define ERR_W                8
`define ERR_RST              8'h00
`define ERR_LIMIT_RST        8'h09
`define SAMPLE_CYC           16'h0001
`define CYC_UNIT_RST         32'h000004E2
`define OW_CNT_RST           16'h000A
`define CW_CNT_RST           16'h000A
`define SRC_SPI              1'b0
`define SRC_PIN              1'b1
`endif

// file: trigger_edge_filter.v
// Falling edge qualifier for the trigger input pin
`timescale 1ns/1ps
module trigger_edge_filter #(
  parameter SAMPLE_CYC = 16
) (
  input  wire clk_i,
  input  wire rstn_i,
  input  wire pin_i,
  output reg  fall_o
);
  reg        sync1_q;
  reg        sync2_q;
  reg [15:0] div_q;
  reg [3:0]  hist_q;
  wire       tick = (div_q == SAMPLE_CYC[15:0] - 16'h0001);

  // Two-stage synchroniser
  always @(posedge clk_i) begin
    if (!rstn_i) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else begin
      sync1_q <= pin_i;
      sync2_q <= sync1_q;
    end
  end

  // Sample history, two highs then two lows
  always @(posedge clk_i) begin
    if (!rstn_i) begin
      div_q  <= 16'h0000;
      hist_q <= 4'h0;
      fall_o <= 1'b0;
    end else begin
      div_q  <= tick ? 16'h0000 : div_q + 16'h0001;
      fall_o <= 1'b0;
      if (tick) begin
        hist_q <= {hist_q[2:0], sync2_q};
        fall_o <= ({hist_q[2:0], sync2_q} == 4'hC); // Decided at second low
      end
    end
  end
endmodule

// file: window_timer.v
// Loadable down counter that times one window
`timescale 1ns/1ps
module window_timer #(
  parameter W = 32
) (
  input  wire         clk_i,
  input  wire         rstn_i,
  input  wire         load_i,
  input  wire [W-1:0] len_i,
  output wire         expire_o
);
  reg [W-1:0] cnt_q;
  reg         run_q;
  assign expire_o = run_q && (cnt_q == {W{1'b0}});

  // Count down to zero once loaded
  always @(posedge clk_i) begin
    if (!rstn_i) begin
      cnt_q <= {W{1'b0}};
      run_q <= 1'b0;
    end else if (load_i) begin
      cnt_q <= (len_i == {W{1'b0}}) ? {W{1'b0}} : len_i - {{(W-1){1'b0}}, 1'b1};
      run_q <= 1'b1;
    end else if (expire_o) begin
      run_q <= 1'b0;
    end else if (run_q) begin
      cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
    end
  end
endmodule

// file: mcu_pin_model.sv
// Microcontroller side of the trigger pin, with pull-down
`timescale 1ns/1ps
module mcu_pin_model (
  input  wire       clk_i,
  input  wire       go_i,
  input  wire [7:0] hi_len_i,
  output wire       pin_o
);
  reg       drv_q = 1'b0;
  reg [7:0] cnt_q = 8'h00;
  // Released pin falls to the pull-down level
  assign pin_o = drv_q;
  // Hold high for the asked span, then release
  always @(posedge clk_i) begin
    if (go_i) begin
      drv_q <= 1'b1;
      cnt_q <= hi_len_i;
    end else if (cnt_q != 8'h00) cnt_q <= cnt_q - 8'h01;
    else drv_q <= 1'b0;
  end
endmodule

// file: windowed_supervisor_assertions.sv
// Port assertions of the windowed supervisor
`timescale 1ns/1ps
module windowed_supervisor_chk #(
  parameter LOW_LONG_CYC  = 100,
  parameter LOW_SHORT_CYC = 60
) (
  input wire       clk_i,
  input wire       rstn_i,
  input wire       cmd_write_i,
  input wire       trigger_source_i,
  input wire       trigger_source_we_i,
  input wire       cycle_time_select_i,
  input wire       mcu_reset_output_o,
  input wire       wdg_irq_o,
  input wire       fault_o,
  input wire       regulators_off_o,
  input wire [7:0] error_count_o,
  input wire [1:0] window_state_o
);
  reg        src_q;
  reg [15:0] long_q;
  // Source copy and long window age
  always @(posedge clk_i) begin
    if (!rstn_i) src_q <= 1'b0;
    else if (trigger_source_we_i) src_q <= trigger_source_i;
    if (!rstn_i || window_state_o != 2'h1) long_q <= 16'h0000;
    else long_q <= long_q + 16'h0001;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // Command taken at one edge; the state it met shows on the copy one cycle later
  sequence s_cmd_in(st);
    cmd_write_i && !src_q ##1 window_state_o == st;
  endsequence
  property p_rst;
    disable iff (1'b0) !rstn_i |=> !mcu_reset_output_o && error_count_o == 8'h00 && window_state_o == 2'h0;
  endproperty
  property p_valid;
    s_cmd_in(2'h3) |=> window_state_o == 2'h2;
  endproperty
  property p_dec;
    s_cmd_in(2'h3) |=> error_count_o == ($past(error_count_o) == 8'h00 ? 8'h00 : $past(error_count_o) - 8'h01);
  endproperty
  property p_cw;
    s_cmd_in(2'h2) |-> wdg_irq_o ##1 window_state_o != 2'h2;
  endproperty
  property p_add;
    wdg_irq_o |=> error_count_o == $past(error_count_o) + 8'h02 || error_count_o == 8'h00;
  endproperty
  property p_irq1;
    wdg_irq_o |=> !wdg_irq_o;
  endproperty
  property p_fault;
    fault_o |=> fault_o && regulators_off_o && window_state_o == 2'h0;
  endproperty
  property p_long;
    long_q <= (cycle_time_select_i ? LOW_LONG_CYC : LOW_SHORT_CYC) + 2;
  endproperty
  property p_soft;
    $fell(mcu_reset_output_o) |-> !mcu_reset_output_o [*5];
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared in reset");
  a_valid: assert property (p_valid) else $error("no closed window");
  a_dec: assert property (p_dec) else $error("bad decrement");
  a_cw: assert property (p_cw) else $error("closed trigger not invalid");
  a_add: assert property (p_add) else $error("bad increment");
  a_irq1: assert property (p_irq1) else $error("irq too long");
  a_fault: assert property (p_fault) else $error("fault not sticky");
  a_long: assert property (p_long) else $error("long window too long");
  a_soft: assert property (p_soft) else $error("reset pulse too short");
endmodule
bind windowed_supervisor windowed_supervisor_chk #(
  .LOW_LONG_CYC (LOW_LONG_CYC),
  .LOW_SHORT_CYC(LOW_SHORT_CYC)
) windowed_supervisor_chk_inst (.clk_i, .rstn_i, .cmd_write_i, .trigger_source_i, .trigger_source_we_i,
  .cycle_time_select_i, .mcu_reset_output_o, .wdg_irq_o, .fault_o, .regulators_off_o, .error_count_o,
  .window_state_o);

// file: tb_windowed_supervisor.sv
// Self-checking bench of the windowed supervisor
`timescale 1ns/1ps
module tb_windowed_supervisor;
  reg        clk_i = 1'b0;
  reg        rstn_i = 1'b0;
  reg        cmd_w = 1'b0;
  reg        src = 1'b0;
  reg        src_we = 1'b0;
  reg        t_we = 1'b0;
  reg        lim_we = 1'b0;
  reg        go = 1'b0;
  reg [7:0]  hi_len = 8'h04;
  reg [7:0]  lim = 8'h04;
  reg        cts = 1'b1;
  reg [31:0] unit = 32'h00000002;
  reg [15:0] owc = 16'h0010;
  reg [15:0] cwc = 16'h000A;
  wire       pin;
  wire       rst_o;
  wire       irq;
  wire       flt;
  wire       roff;
  wire [7:0] err;
  wire [1:0] st;
  integer    miscompares = 0;
  integer    comparisons = 0;
  integer    i;
  always #4 clk_i = ~clk_i;
  mcu_pin_model mcu_pin_model_inst (.clk_i(clk_i), .go_i(go), .hi_len_i(hi_len), .pin_o(pin));
  windowed_supervisor #(.LOW_LONG_CYC(100), .LOW_SHORT_CYC(60), .INIT_CYC(200), .SAMPLE_CYC(2),
    .RST_HOLD_CYC(4)) windowed_supervisor_inst (.clk_i(clk_i), .rstn_i(rstn_i), .trigger_input_pin_i(pin),
    .cmd_write_i(cmd_w), .trigger_source_i(src), .trigger_source_we_i(src_we), .cycle_time_select_i(cts),
    .cycle_unit_i(unit), .open_window_count_i(owc), .closed_window_setting_i(cwc),
    .timing_we_i(t_we), .error_count_limit_i(lim), .error_count_limit_we_i(lim_we), .mcu_reset_output_o(rst_o),
    .wdg_irq_o(irq), .fault_o(flt), .regulators_off_o(roff), .error_count_o(err), .window_state_o(st));
  task give_verdict;
    begin
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  task chk(input [63:0] nm, input [7:0] e, input [7:0] g);
    begin
      comparisons = comparisons + 1;
      if (e !== g) begin
        miscompares = miscompares + 1;
        $display("[ERR] %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task tick(input integer n);
    repeat (n) @(posedge clk_i);
  endtask
  // Command trigger, returns once the state copy has moved
  task trig;
    begin
      tick(1);
      cmd_w <= 1'b1;
      tick(1);
      cmd_w <= 1'b0;
      tick(1);
      #1;
    end
  endtask
  task wait_st(input [1:0] s, input integer n);
    begin
      i = 0;
      while (st !== s && i < n) begin
        tick(1);
        #1;
        i = i + 1;
      end
      chk("state", s, st);
    end
  endtask
  // Wait for reset low, irq or fault
  task wt(input integer sel, input integer n);
    begin
      i = 0;
      while ((sel == 0 ? rst_o !== 1'b0 : sel == 1 ? irq !== 1'b1 : flt !== 1'b1) && i < n) begin
        tick(1);
        #1;
        i = i + 1;
      end
      chk("wait", 8'h00, (i < n) ? 8'h00 : 8'hFF);
    end
  endtask
  task pulse_pin(input [7:0] n);
    begin
      tick(1);
      hi_len <= n;
      go <= 1'b1;
      tick(1);
      go <= 1'b0;
    end
  endtask
  initial begin
    tick(10);
    #1;
    chk("rst", 8'h00, rst_o);
    chk("err", 8'h00, err);
    tick(1);
    rstn_i <= 1'b1;
    wait_st(2'h1, 6);
    chk("rst", 8'h01, rst_o);
    pulse_pin(8'h04);
    tick(20);
    #1;
    chk("state", 8'h01, st);
    tick(1);
    t_we <= 1'b1;
    tick(1);
    t_we <= 1'b0;
    wait_st(2'h3, 6);
    trig;
    chk("err", 8'h00, err);
    chk("state", 8'h02, st);
    tick(8);
    #1;
    chk("state", 8'h02, st);
    wait_st(2'h3, 20);
    trig;
    trig;
    chk("err", 8'h02, err);
    chk("state", 8'h03, st);
    trig;
    chk("err", 8'h01, err);
    wait_st(2'h3, 25);
    wt(1, 45);
    tick(1);
    #1;
    chk("err", 8'h03, err);
    tick(1);
    src <= 1'b1;
    src_we <= 1'b1;
    tick(1);
    src_we <= 1'b0;
    pulse_pin(8'h04);
    wait_st(2'h2, 20);
    chk("err", 8'h02, err);
    wait_st(2'h3, 25);
    pulse_pin(8'h08);
    tick(6);
    #1;
    chk("state", 8'h03, st);
    wait_st(2'h2, 25);
    chk("err", 8'h01, err);
    tick(1);
    src <= 1'b0;
    src_we <= 1'b1;
    lim_we <= 1'b1;
    cts <= 1'b0;
    tick(1);
    src_we <= 1'b0;
    lim_we <= 1'b0;
    trig;
    chk("err", 8'h03, err);
    trig;
    trig;
    wt(0, 4);
    tick(1);
    #1;
    chk("err", 8'h00, err);
    wait_st(2'h1, 30);
    wt(0, 400);
    chk("lowlen", 8'h3B, i[7:0]);
    wt(2, 800);
    tick(2);
    #1;
    chk("regoff", 8'h01, roff);
    chk("state", 8'h00, st);
    give_verdict;
  end
  // Hang guard, well beyond the planned run
  initial begin
    #40000;
    miscompares = miscompares + 1;
    give_verdict;
  end
endmodule
